//--- dv/host_model.sv
// Host model driving the register port of the mode block
`default_nettype none
module host_model (
    // Clock
    input wire logic clk,
    // Register port
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    // Reserved source and formula codes appear only in fallback probes
    // Idle lines show the inverse, so a stale address never looks held
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(posedge clk) #1;
        {reg_wr, reg_addr, reg_wdata} = {1'b0, ~a, ~d};
    endtask
    // Answer is taken once the strobe edge has landed
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk) #1;
        {reg_rd, reg_addr} = {1'b1, a};
        @(posedge clk) #1;
        {reg_rd, reg_addr} = {1'b0, ~a};
        d = reg_rdata;
    endtask
endmodule // host_model
`default_nettype wire

//--- dv/tb_wave_watt_mode.sv
// Self-checking bench for the waveform and active energy mode block
`default_nettype none
module tb_wave_watt_mode;
    timeunit 1ns;
    timeprecision 100ps;
    logic CORE_CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic REG_WR;
    logic REG_RD;
    logic [7:0] REG_ADDR;
    logic [7:0] REG_WDATA;
    logic [7:0] REG_RDATA;
    logic REG_RVALID;
    logic SAMPLE_STROBE = 1'b0;
    wave_watt_pkg::phase_samples_t SAMPLES = '{16'sd2, 16'sd3, 16'sd5, 16'sd7, -16'sd11, 16'sd13};
    wave_watt_pkg::sum_t REACTIVE_POWER = '0;
    wave_watt_pkg::sample_t WAVE_SAMPLE;
    logic WAVE_SAMPLE_VALID;
    wave_watt_pkg::sum_t ACTIVE_POWER;
    wave_watt_pkg::sum_t LINE_ACCUM_POWER;
    logic LINE_REACTIVE_SELECTED;
    logic [2:0] NEG_POWER;
    int mismatches = 0;
    int n_checks = 0;
    int n;
    logic [7:0] rdv;
    // 25 MHz clock
    always #20 CORE_CLK = ~CORE_CLK;
    host_model host_model_inst (.clk(CORE_CLK), .reg_wr(REG_WR), .reg_rd(REG_RD),
        .reg_addr(REG_ADDR), .reg_wdata(REG_WDATA), .reg_rdata(REG_RDATA));
    wave_watt_mode wave_watt_mode_inst (.*);
    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic strobe;
        @(posedge CORE_CLK) #1;
        SAMPLE_STROBE = 1'b1;
        @(posedge CORE_CLK) #1;
        SAMPLE_STROBE = 1'b0;
    endtask
    // Counts edges up to the next update; gives up at lim
    task automatic wait_valid(input int lim);
        n = 0;
        do begin
            @(posedge CORE_CLK) #1;
            n++;
        end while (WAVE_SAMPLE_VALID !== 1'b1 && n < lim);
    endtask
    // Terms for samples 2,3,5 and 7,-11,13; reserved formula behaves as the first
    function automatic int term(input int f, input int k);
        if (k == 0) return (f == 1 || f == 2) ? 36 : 14;
        if (k == 1) return (f == 1 || f == 2) ? 0 : -33;
        return (f == 1) ? 120 : 65;
    endfunction
    function automatic int psum(input int f, input logic [2:0] en);
        return (en[2] ? term(f, 0) : 0) + (en[1] ? term(f, 1) : 0) + (en[0] ? term(f, 2) : 0);
    endfunction
    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic t_reset;
        chk(ACTIVE_POWER, 36'h0);
        chk({NEG_POWER, WAVE_SAMPLE_VALID}, 4'h0);
        host_model_inst.rd(8'h0c, rdv);
        chk(rdv, 8'h00);
        host_model_inst.rd(8'h0d, rdv);
        chk(rdv, 8'h3f);
        host_model_inst.rd(8'h0e, rdv);
        chk({REG_RVALID, rdv}, 9'h100);
        host_model_inst.wr(8'h0c, 8'hc0);
        host_model_inst.rd(8'h0c, rdv);
        chk(rdv, 8'hc0);
    endtask
    // Every formula with every term mask; line mask is the complement
    task automatic t_energy;
        logic [2:0] e;
        int f;
        for (int i = 0; i < 32; i++) begin
            f = i / 8;
            e = i[2:0];
            host_model_inst.wr(8'h0d, {i[4:3], e, ~e});
            strobe();
            chk(ACTIVE_POWER, 36'(psum(f, e)));
            chk(LINE_ACCUM_POWER, 36'(psum(f, ~e)));
            chk(NEG_POWER, {1'b0, e[1] && (f == 0 || f == 3), 1'b0});
        end
    endtask
    task automatic t_reactive;
        host_model_inst.wr(8'h0c, 8'h20);
        chk(LINE_REACTIVE_SELECTED, 1'b1);
        REACTIVE_POWER = 36'h812345678;
        strobe();
        chk(LINE_ACCUM_POWER, 36'h812345678);
        host_model_inst.wr(8'h0c, 8'h00);
        chk(LINE_REACTIVE_SELECTED, 1'b0);
    endtask
    task automatic t_wave;
        int ch[6] = '{2, 3, 5, 7, -11, 13};
        for (int s = 0; s < 6; s++) begin
            host_model_inst.wr(8'h0c, 8'(s));
            wait_valid(500);
            chk(WAVE_SAMPLE, 16'(ch[s]));
        end
        // First gap after a rate change may be short, so the second is timed
        for (int r = 0; r < 4; r++) begin
            host_model_inst.wr(8'h0c, 8'(r * 8));
            wait_valid(4000);
            wait_valid(4000);
            chk(n, 384 << r);
        end
        host_model_inst.wr(8'h0c, 8'h06);
        wait_valid(800);
        chk(n, 800);
    endtask
    // Reset held over three rising edges, released just after the third
    initial begin
        repeat (3) @(posedge CORE_CLK);
        #1;
        RESET_N = 1'b1;
        t_reset();
        t_energy();
        t_reactive();
        t_wave();
        end_sim();
    end
    // Watchdog well beyond the longest expected run
    initial begin
        #1000000;
        mismatches++;
        end_sim();
    end
endmodule // tb_wave_watt_mode
`default_nettype wire

//--- dv/wave_watt_mode_sva.sv
// Checker for the waveform and active energy mode registers
`default_nettype none
module wave_watt_mode_sva (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    // Register port and datapath
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic [7:0] REG_RDATA,
    input wire logic SAMPLE_STROBE,
    input wire wave_watt_pkg::phase_samples_t SAMPLES,
    input wire wave_watt_pkg::sum_t REACTIVE_POWER,
    input wire wave_watt_pkg::sample_t WAVE_SAMPLE,
    input wire logic WAVE_SAMPLE_VALID,
    input wire wave_watt_pkg::sum_t ACTIVE_POWER,
    input wire wave_watt_pkg::sum_t LINE_ACCUM_POWER,
    input wire logic LINE_REACTIVE_SELECTED,
    input wire logic [2:0] NEG_POWER
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] wav_q;
    logic [7:0] wat_q;
    // Shadow copies rebuilt from writes, so checks never trust the design's own store
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            {wav_q, wat_q} <= 16'h003f;
        end else if (REG_WR && REG_ADDR == 8'h0c) begin
            wav_q <= REG_WDATA;
        end else if (REG_WR && REG_ADDR == 8'h0d) begin
            wat_q <= REG_WDATA;
        end
    end
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);
    // Read answer one cycle later, old value when written in the same cycle
    property p_read_data;
        REG_RD |=> REG_RDATA == ($past(REG_ADDR) == 8'h0c ? $past(wav_q) :
            $past(REG_ADDR) == 8'h0d ? $past(wat_q) : 8'h00);
    endproperty
    a_read_data: assert property (p_read_data) else $error("read data wrong");
    property p_src_route;
        WAVE_SAMPLE_VALID |-> WAVE_SAMPLE == $past(SAMPLES[95-16*wav_q[2:0] -: 16]);
    endproperty
    a_src_route: assert property (p_src_route) else $error("wrong sample source");
    property p_src_reserved;
        $past(wav_q[2:1]) == 2'b11 |-> !WAVE_SAMPLE_VALID;
    endproperty
    a_src_reserved: assert property (p_src_reserved) else $error("reserved source");
    // Fastest rate still leaves hundreds of cycles between updates
    property p_valid_pulse;
        WAVE_SAMPLE_VALID |=> !WAVE_SAMPLE_VALID [*8];
    endproperty
    a_valid_pulse: assert property (p_valid_pulse) else $error("update too soon");
    property p_lvar_flag;
        LINE_REACTIVE_SELECTED == wav_q[5];
    endproperty
    a_lvar_flag: assert property (p_lvar_flag) else $error("reactive flag wrong");
    property p_lvar_src;
        $past(SAMPLE_STROBE && wav_q[5]) |-> LINE_ACCUM_POWER == $past(REACTIVE_POWER);
    endproperty
    a_lvar_src: assert property (p_lvar_src) else $error("line source wrong");
    property p_no_terms;
        $past(SAMPLE_STROBE) && $past(wat_q[5:3]) == 3'h0 |-> ACTIVE_POWER == '0;
    endproperty
    a_no_terms: assert property (p_no_terms) else $error("disabled terms summed");
    property p_neg_gate;
        $past(SAMPLE_STROBE) |-> (NEG_POWER & ~{$past(wat_q[3]), $past(wat_q[4]),
            $past(wat_q[5])}) == 3'h0;
    endproperty
    a_neg_gate: assert property (p_neg_gate) else $error("negative flag ungated");
endmodule // wave_watt_mode_sva
bind wave_watt_mode wave_watt_mode_sva wave_watt_mode_sva_inst (.*);
`default_nettype wire

//--- hw/wave_rate_divider.sv
// Divider giving the waveform sample update strobe for the selected rate
`default_nettype none

module wave_rate_divider (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Rate code, each step halves the rate
    input wire logic [1:0] rate_sel,
    // One-cycle update strobe
    output logic tick
);

    logic [wave_watt_pkg::WAVE_CNT_W-1:0] cnt_q, cnt_d;
    logic [wave_watt_pkg::WAVE_CNT_W-1:0] limit;
    logic tick_d;

    // ------------------------------------------------------------------
    // Count period: base cycles shifted by the rate code
    // ------------------------------------------------------------------
    always_comb begin
        limit = wave_watt_pkg::WAVE_CNT_W'(wave_watt_pkg::WAVE_BASE_CYCLES)
                << rate_sel; // [RULE2]
        limit = limit - 12'h001;
        // A rate change that shrinks the period to or below the count restarts at once, never wraps late
        if (cnt_q >= limit) begin
            cnt_d = 12'h000;
            tick_d = 1'b1;
        end else begin
            cnt_d = cnt_q + 12'h001;
            tick_d = 1'b0;
        end
    end

    // Counter and strobe registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 12'h000;
            tick <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick <= tick_d;
        end
    end

endmodule : wave_rate_divider

`default_nettype wire

//--- hw/wave_watt_mode.sv
// Waveform sample mode and active energy phase mode registers with their datapath
//
// Operation
// [RULE1] Source field routes one channel to waveform
// [RULE2] Rate field: base clock/3/128, halving per code
// [RULE3] Bit five picks reactive line accumulation source
// [RULE4] Low three bits enable line active terms
// [RULE5] Bits three to five enable active terms
// [RULE6] Term enables also gate per-phase negative detection
// [RULE7] Every term-enable combination is accepted
// [RULE8] Bits six-seven choose the active formula
// [RULE9] Formula codes map to three documented sums
// [RULE10] Host avoids reserved source and formula codes
`default_nettype none

module wave_watt_mode (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    // Register access from the serial port
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    output logic REG_RVALID,
    // ADC samples and reactive power from the datapath
    input wire logic SAMPLE_STROBE,
    input wire wave_watt_pkg::phase_samples_t SAMPLES,
    input wire wave_watt_pkg::sum_t REACTIVE_POWER,
    // Waveform sample output
    output wave_watt_pkg::sample_t WAVE_SAMPLE,
    output logic WAVE_SAMPLE_VALID,
    // Energy results
    output wave_watt_pkg::sum_t ACTIVE_POWER,
    output wave_watt_pkg::sum_t LINE_ACCUM_POWER,
    output logic LINE_REACTIVE_SELECTED,
    output logic [2:0] NEG_POWER
);

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    wave_watt_pkg::waveform_sample_mode_t wmode_q, wmode_d;
    wave_watt_pkg::active_energy_phase_mode_t amode_q, amode_d;
    logic [7:0] rdata_d;
    logic rvalid_d;

    // Write decode and read mux; unmapped reads return zero
    always_comb begin
        wmode_d = wmode_q;
        amode_d = amode_q;
        if (REG_WR && REG_ADDR == wave_watt_pkg::ADDR_WAVEFORM_SAMPLE_MODE) begin
            wmode_d = wave_watt_pkg::waveform_sample_mode_t'(REG_WDATA);
        end
        if (REG_WR && REG_ADDR == wave_watt_pkg::ADDR_ACTIVE_ENERGY_PHASE_MODE) begin
            amode_d = wave_watt_pkg::active_energy_phase_mode_t'(REG_WDATA); // [RULE7]
        end
        rvalid_d = REG_RD;
        case (REG_ADDR)
            wave_watt_pkg::ADDR_WAVEFORM_SAMPLE_MODE: rdata_d = wmode_q;
            wave_watt_pkg::ADDR_ACTIVE_ENERGY_PHASE_MODE: rdata_d = amode_q;
            default: rdata_d = 8'h00;
        endcase
        if (!REG_RD) begin
            rdata_d = 8'h00;
        end
    end

    // Register file flops
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wmode_q <= wave_watt_pkg::WAVEFORM_SAMPLE_MODE_RST;
            amode_q <= wave_watt_pkg::ACTIVE_ENERGY_PHASE_MODE_RST;
            REG_RDATA <= 8'h00;
            REG_RVALID <= 1'b0;
        end else begin
            wmode_q <= wmode_d;
            amode_q <= amode_d;
            REG_RDATA <= rdata_d;
            REG_RVALID <= rvalid_d;
        end
    end

    // ------------------------------------------------------------------
    // Waveform sampling
    // ------------------------------------------------------------------
    logic rate_tick;
    wave_watt_pkg::sample_t wave_d;
    logic wave_valid_d;

    wave_rate_divider u_rate (
        .clk(CORE_CLK),
        .rst_n(RESET_N),
        .rate_sel(wmode_q.sample_rate_select), // [RULE2]
        .tick(rate_tick)
    );

    // Reserved source codes hold the last sample and raise no strobe
    always_comb begin
        wave_d = WAVE_SAMPLE;
        wave_valid_d = 1'b0;
        if (rate_tick) begin
            wave_valid_d = 1'b1;
            case (wmode_q.sample_source_select) // [RULE1]
                wave_watt_pkg::SRC_VOLT_A: wave_d = SAMPLES.volt_a;
                wave_watt_pkg::SRC_VOLT_B: wave_d = SAMPLES.volt_b;
                wave_watt_pkg::SRC_VOLT_C: wave_d = SAMPLES.volt_c;
                wave_watt_pkg::SRC_CURR_A: wave_d = SAMPLES.curr_a;
                wave_watt_pkg::SRC_CURR_B: wave_d = SAMPLES.curr_b;
                wave_watt_pkg::SRC_CURR_C: wave_d = SAMPLES.curr_c;
                default: wave_valid_d = 1'b0; // [RULE10]
            endcase
        end
    end

    // Waveform output flops
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            WAVE_SAMPLE <= 16'sh0000;
            WAVE_SAMPLE_VALID <= 1'b0;
        end else begin
            WAVE_SAMPLE <= wave_d;
            WAVE_SAMPLE_VALID <= wave_valid_d;
        end
    end

    // ------------------------------------------------------------------
    // Active energy terms
    // ------------------------------------------------------------------
    logic signed [16:0] va, vb, vc, ia, ib, ic;
    logic signed [16:0] ia_b, ic_b;
    wave_watt_pkg::prod_t term [3];
    wave_watt_pkg::sum_t act_d, line_d;
    logic [2:0] neg_d;

    // Widen by one bit so current differences cannot overflow
    always_comb begin
        va = 17'(SAMPLES.volt_a);
        vb = 17'(SAMPLES.volt_b);
        vc = 17'(SAMPLES.volt_c);
        ia = 17'(SAMPLES.curr_a);
        ib = 17'(SAMPLES.curr_b);
        ic = 17'(SAMPLES.curr_c);
        ia_b = ia - ib;
        ic_b = ic - ib;
        // Reserved formula code falls back to the four-wire sum
        case (amode_q.active_formula_select) // [RULE8]
            wave_watt_pkg::FORMULA_THREE_WIRE: begin
                term[0] = va * ia_b; // [RULE9]
                term[1] = 34'sh0;
                term[2] = vc * ic_b;
            end
            wave_watt_pkg::FORMULA_MIXED: begin
                term[0] = va * ia_b; // [RULE9]
                term[1] = 34'sh0;
                term[2] = vc * ic;
            end
            default: begin
                term[0] = va * ia; // [RULE9]
                term[1] = vb * ib;
                term[2] = vc * ic;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Term enables in term order
    // ------------------------------------------------------------------
    logic [2:0] act_en;
    logic [2:0] line_en;

    // Reverse once here so the bit-to-term pairing lives in one place
    always_comb begin
        for (int k = 0; k < 3; k++) begin
            act_en[k] = amode_q.active_term_enable[2-k]; // [RULE5]
            line_en[k] = amode_q.line_active_term_enable[2-k]; // [RULE4]
        end
    end

    // Sum enabled terms; first term is the highest enable bit
    always_comb begin
        act_d = ACTIVE_POWER;
        line_d = LINE_ACCUM_POWER;
        neg_d = NEG_POWER;
        if (SAMPLE_STROBE) begin
            act_d = 36'sh0;
            line_d = 36'sh0;
            for (int k = 0; k < 3; k++) begin
                if (act_en[k]) begin
                    act_d = act_d + wave_watt_pkg::sum_t'(term[k]); // [RULE5]
                end
                if (line_en[k]) begin
                    line_d = line_d + wave_watt_pkg::sum_t'(term[k]); // [RULE4]
                end
                // Detection off for a phase whose term is dropped
                neg_d[k] = act_en[k] && term[k][33]; // [RULE6]
            end
            if (wmode_q.line_reactive_accum_select) begin
                line_d = REACTIVE_POWER; // [RULE3]
            end
        end
    end

    // Energy result flops
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ACTIVE_POWER <= 36'sh0;
            LINE_ACCUM_POWER <= 36'sh0;
            NEG_POWER <= 3'h0;
            LINE_REACTIVE_SELECTED <= 1'b0;
        end else begin
            ACTIVE_POWER <= act_d;
            LINE_ACCUM_POWER <= line_d;
            NEG_POWER <= neg_d;
            LINE_REACTIVE_SELECTED <= wmode_d.line_reactive_accum_select; // [RULE3]
        end
    end

endmodule : wave_watt_mode

`default_nettype wire

//--- hw/wave_watt_pkg.sv
// Constants, field layouts and carrier types for the waveform and active energy mode registers
`default_nettype none

package wave_watt_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_WAVEFORM_SAMPLE_MODE = 8'h0c;
    localparam logic [7:0] ADDR_ACTIVE_ENERGY_PHASE_MODE = 8'h0d;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int SRC_LSB = 0;
    localparam int RATE_LSB = 3;
    localparam int LVAR_BIT = 5;
    localparam int LINE_TERM_LSB = 0;
    localparam int TERM_LSB = 3;
    localparam int FORMULA_LSB = 6;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] WAVEFORM_SAMPLE_MODE_RST = 8'h00;
    localparam logic [7:0] ACTIVE_ENERGY_PHASE_MODE_RST = 8'h3f;

    // ------------------------------------------------------------------
    // Timing: master clock / 3 / 128 for the fastest sample rate
    // ------------------------------------------------------------------
    localparam int WAVE_PRE_DIV = 3;
    localparam int WAVE_BASE_DIV = 128;
    localparam int WAVE_BASE_CYCLES = WAVE_PRE_DIV * WAVE_BASE_DIV;
    localparam int WAVE_CNT_W = 12;

    // ------------------------------------------------------------------
    // Data widths
    // ------------------------------------------------------------------
    localparam int SAMPLE_W = 16;
    localparam int PROD_W = 34;
    localparam int SUM_W = 36;

    // Sample source codes
    typedef enum logic [2:0] {
        SRC_VOLT_A = 3'h0,
        SRC_VOLT_B = 3'h1,
        SRC_VOLT_C = 3'h2,
        SRC_CURR_A = 3'h3,
        SRC_CURR_B = 3'h4,
        SRC_CURR_C = 3'h5
    } sample_source_select_t;

    // Active energy formula codes
    typedef enum logic [1:0] {
        FORMULA_FOUR_WIRE = 2'h0,
        FORMULA_THREE_WIRE = 2'h1,
        FORMULA_MIXED = 2'h2
    } active_formula_select_t;

    typedef logic signed [SAMPLE_W-1:0] sample_t;
    typedef logic signed [PROD_W-1:0] prod_t;
    typedef logic signed [SUM_W-1:0] sum_t;

    // Six ADC channels presented together
    typedef struct packed {
        sample_t volt_a;
        sample_t volt_b;
        sample_t volt_c;
        sample_t curr_a;
        sample_t curr_b;
        sample_t curr_c;
    } phase_samples_t;

    // Waveform sample mode register layout
    typedef struct packed {
        logic reserved_7_6_hi;
        logic reserved_7_6_lo;
        logic line_reactive_accum_select;
        logic [1:0] sample_rate_select;
        logic [2:0] sample_source_select;
    } waveform_sample_mode_t;

    // Active energy phase mode register layout
    typedef struct packed {
        logic [1:0] active_formula_select;
        logic [2:0] active_term_enable;
        logic [2:0] line_active_term_enable;
    } active_energy_phase_mode_t;

endpackage : wave_watt_pkg

`default_nettype wire
